// ==== src/p2m_evt_bit.v ====
`timescale 1ns/1ps

// Sticky event flag; a set in the same cycle as a clear wins
module p2m_evt_bit (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Control
    input wire set,
    input wire clr,
    // Flag
    output reg flag_r
);

    wire flag_nxt;

    assign flag_nxt = set | (flag_r & ~clr);

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule

// ==== src/p2m_map.vh ====
`ifndef P2M_MAP_VH
`define P2M_MAP_VH

// Register byte offsets
`define P2M_OFS_BASIC_CONTROL 8'h58
`define P2M_OFS_BASIC_STATUS 8'h5a
`define P2M_OFS_ID_LOW 8'h5c
`define P2M_OFS_ID_HIGH 8'h5e
`define P2M_OFS_ADVERTISE 8'h60
`define P2M_OFS_PARTNER 8'h62
`define P2M_OFS_RSVD_LO 8'h64
`define P2M_OFS_RSVD_HI 8'h65
`define P2M_OFS_EVT_STATUS 8'hf0
`define P2M_OFS_EVT_MASK 8'hf2

// Basic control fields
`define P2M_BC_DIS_MDIX 3
`define P2M_BC_DIS_FEF 2
`define P2M_BC_DIS_TX 1

// Fourth control register fields
`define P2M_CR4_DIS_TX 14
`define P2M_CR4_DIS_FEF 12
`define P2M_CR4_DIS_MDIX 10
`define P2M_CR4_PAUSE 4
`define P2M_CR4_ADV_HI 3
`define P2M_CR4_ADV_LO 0

// Port status register fields
`define P2M_SR_ANEG_DONE 6
`define P2M_SR_LINK 5
`define P2M_SR_PAUSE 4
`define P2M_SR_FEF 8
`define P2M_SR_ABIL_HI 3
`define P2M_SR_ABIL_LO 0

// Basic status fields
`define P2M_BS_CAPS_HI 15
`define P2M_BS_CAPS_LO 11
`define P2M_BS_ANEG_DONE 5
`define P2M_BS_FEF 4
`define P2M_BS_ANEG_ABLE 3
`define P2M_BS_LINK 2

// Advertisement and partner fields
`define P2M_AN_PAUSE 10
`define P2M_AN_ABIL_HI 8
`define P2M_AN_ABIL_LO 5
`define P2M_AN_SEL_HI 4
`define P2M_AN_SEL_LO 0

// Reset and fixed values
`define P2M_RST_DIS_MDIX 1'b0
`define P2M_RST_DIS_FEF 1'b0
`define P2M_RST_DIS_TX 1'b0
`define P2M_RST_PAUSE 1'b1
`define P2M_RST_ADV 4'hf
`define P2M_CAPS 5'h0f
`define P2M_SELECTOR 5'h01
`define P2M_RST_EVT_MASK 4'h0

// Event bit positions
`define P2M_EV_LINK 0
`define P2M_EV_ANEG 1
`define P2M_EV_FEF 2
`define P2M_EV_PARTNER 3
`define P2M_EV_COUNT 4

`endif

// ==== src/p2m_regs.v ====
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "p2m_map.vh"

// What this block does
// - Control bit 3 disables auto crossover; shared with fourth control bit 10.
// - Control bit 2 disables far-end-fault detection (fiber); shared with bit 12.
// - Control bit 1 disables transmit, default 0; shared with fourth control bit 14.
// - Status bits 15..11 fixed: T4 reads 0, four TX/T capability flags read 1.
// - Status bit 5 shows auto-negotiation complete, from port status bit 6.
// - Status bit 4 shows far-end fault, from port status bit 8.
// - Status bit 3 always reads 1, auto-negotiation capable.
// - Status bit 2 shows link up, from port status bit 5.
// - Preamble suppression bit 6 and jabber bit 1 always read 0.
// - Status bit 0 reads 0, no extended register capability.
// - Two fixed read-only identifier words; writes do nothing.
// - Advertise bit 10 pause, writable, default 1, shared with fourth control bit 4.
// - Advertise bits 8..5 writable, default 1, shared with fourth control bits 3..0.
// - Partner bit 10 read-only, from port status bit 4.
// - Partner bits 8..5 read-only, from port status bits 3..0.
// - Bytes 0x064-0x065 reserved, no function.
module p2m_regs #(
    // Identifier words; both values are arbitrary
    parameter [15:0] ID_LOW = 16'h5a5a,
    parameter [15:0] ID_HIGH = 16'h0c3c
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_r,
    // Fourth control register, written from its own side
    input wire cr4_wr,
    input wire [15:0] cr4_wdata,
    // Port status register
    input wire [15:0] port2_status,
    // Control levels to the PHY and port logic
    output wire dis_auto_mdix,
    output wire dis_far_end_fault,
    output wire dis_transmit,
    output wire adv_pause,
    output wire [3:0] adv_abilities,
    // Interrupt
    output wire irq
);

    reg dis_mdix_r;
    reg dis_mdix_nxt;
    reg dis_fef_r;
    reg dis_fef_nxt;
    reg dis_tx_r;
    reg dis_tx_nxt;
    reg pause_r;
    reg pause_nxt;
    reg [3:0] adv_r;
    reg [3:0] adv_nxt;
    reg [`P2M_EV_COUNT-1:0] evt_mask_r;
    reg [`P2M_EV_COUNT-1:0] evt_mask_nxt;
    reg link_prev_r;
    reg aneg_prev_r;
    reg fef_prev_r;
    reg [4:0] partner_prev_r;
    reg [15:0] rd_mux;

    wire wr_ctl;
    wire wr_adv;
    wire wr_mask;
    wire wr_evt;
    wire [15:0] basic_control;
    wire [15:0] basic_status;
    wire [15:0] advertise;
    wire [15:0] partner;
    wire link_now;
    wire aneg_now;
    wire fef_now;
    wire [4:0] partner_now;
    wire [`P2M_EV_COUNT-1:0] evt_set;
    wire [`P2M_EV_COUNT-1:0] evt_clr;
    wire [`P2M_EV_COUNT-1:0] evt_flag;
    wire [15:0] evt_status;
    wire [15:0] evt_mask_word;

    // Write decode; any offset outside the map is ignored
    assign wr_ctl = reg_wr & (reg_addr == `P2M_OFS_BASIC_CONTROL);
    assign wr_adv = reg_wr & (reg_addr == `P2M_OFS_ADVERTISE);
    assign wr_mask = reg_wr & (reg_addr == `P2M_OFS_EVT_MASK);
    assign wr_evt = reg_wr & (reg_addr == `P2M_OFS_EVT_STATUS);

    // Shared control bits: this view and the fourth control register write one store.
    // Should both write in one cycle, the register port write is taken.
    always @* begin
        dis_mdix_nxt = dis_mdix_r;
        dis_fef_nxt = dis_fef_r;
        dis_tx_nxt = dis_tx_r;
        if (cr4_wr) begin
            dis_mdix_nxt = cr4_wdata[`P2M_CR4_DIS_MDIX];
            dis_fef_nxt = cr4_wdata[`P2M_CR4_DIS_FEF];
            dis_tx_nxt = cr4_wdata[`P2M_CR4_DIS_TX];
        end
        if (wr_ctl) begin
            dis_mdix_nxt = reg_wdata[`P2M_BC_DIS_MDIX];
            dis_fef_nxt = reg_wdata[`P2M_BC_DIS_FEF];
            dis_tx_nxt = reg_wdata[`P2M_BC_DIS_TX];
        end
    end

    always @* begin
        pause_nxt = pause_r;
        adv_nxt = adv_r;
        if (cr4_wr) begin
            pause_nxt = cr4_wdata[`P2M_CR4_PAUSE];
            adv_nxt = cr4_wdata[`P2M_CR4_ADV_HI:`P2M_CR4_ADV_LO];
        end
        if (wr_adv) begin
            pause_nxt = reg_wdata[`P2M_AN_PAUSE];
            adv_nxt = reg_wdata[`P2M_AN_ABIL_HI:`P2M_AN_ABIL_LO];
        end
    end

    always @* begin
        evt_mask_nxt = evt_mask_r;
        if (wr_mask) begin
            evt_mask_nxt = reg_wdata[`P2M_EV_COUNT-1:0];
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dis_mdix_r <= `P2M_RST_DIS_MDIX;
            dis_fef_r <= `P2M_RST_DIS_FEF;
            dis_tx_r <= `P2M_RST_DIS_TX;
        end else begin
            dis_mdix_r <= dis_mdix_nxt;
            dis_fef_r <= dis_fef_nxt;
            dis_tx_r <= dis_tx_nxt;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pause_r <= `P2M_RST_PAUSE;
            adv_r <= `P2M_RST_ADV;
        end else begin
            pause_r <= pause_nxt;
            adv_r <= adv_nxt;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            evt_mask_r <= `P2M_RST_EVT_MASK;
        end else begin
            evt_mask_r <= evt_mask_nxt;
        end
    end

    assign dis_auto_mdix = dis_mdix_r;
    assign dis_far_end_fault = dis_fef_r;
    assign dis_transmit = dis_tx_r;
    assign adv_pause = pause_r;
    assign adv_abilities = adv_r;

    // Mirrored status from the port
    assign link_now = port2_status[`P2M_SR_LINK];
    assign aneg_now = port2_status[`P2M_SR_ANEG_DONE];
    assign fef_now = port2_status[`P2M_SR_FEF];
    assign partner_now = {port2_status[`P2M_SR_PAUSE],
                          port2_status[`P2M_SR_ABIL_HI:`P2M_SR_ABIL_LO]};

    // Only the low control bits live here; upper bits and bit 0 read as zero
    assign basic_control = {12'h000,
                            dis_mdix_r,
                            dis_fef_r,
                            dis_tx_r,
                            1'b0};

    assign basic_status = {`P2M_CAPS,
                           4'h0,
                           1'b0,
                           aneg_now,
                           fef_now,
                           1'b1,
                           link_now,
                           1'b0,
                           1'b0};

    assign advertise = {5'h00,
                        pause_r,
                        1'b0,
                        adv_r,
                        `P2M_SELECTOR};

    assign partner = {5'h00,
                      partner_now[4],
                      1'b0,
                      partner_now[3:0],
                      `P2M_SELECTOR};

    // Previous samples for change detection
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            link_prev_r <= 1'b0;
            aneg_prev_r <= 1'b0;
            fef_prev_r <= 1'b0;
            partner_prev_r <= 5'h00;
        end else begin
            link_prev_r <= link_now;
            aneg_prev_r <= aneg_now;
            fef_prev_r <= fef_now;
            partner_prev_r <= partner_now;
        end
    end

    // Events: link change, negotiation done, fault seen, partner abilities changed
    assign evt_set[`P2M_EV_LINK] = link_now ^ link_prev_r;
    assign evt_set[`P2M_EV_ANEG] = aneg_now & ~aneg_prev_r;
    assign evt_set[`P2M_EV_FEF] = fef_now & ~fef_prev_r;
    assign evt_set[`P2M_EV_PARTNER] = |(partner_now ^ partner_prev_r);

    assign evt_clr = wr_evt ? reg_wdata[`P2M_EV_COUNT-1:0] : {`P2M_EV_COUNT{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < `P2M_EV_COUNT; gi = gi + 1) begin : g_evt
            p2m_evt_bit u_evt (
                .clock(clock),
                .arst_n(arst_n),
                .set(evt_set[gi]),
                .clr(evt_clr[gi]),
                .flag_r(evt_flag[gi])
            );
        end
    endgenerate

    assign irq = |(evt_flag & evt_mask_r);

    assign evt_status = {{(16-`P2M_EV_COUNT){1'b0}}, evt_flag};
    assign evt_mask_word = {{(16-`P2M_EV_COUNT){1'b0}}, evt_mask_r};

    // Read mux; unmapped and reserved offsets answer zero
    always @* begin
        rd_mux = 16'h0000;
        case (reg_addr)
            `P2M_OFS_BASIC_CONTROL: begin
                rd_mux = basic_control;
            end
            `P2M_OFS_BASIC_STATUS: begin
                rd_mux = basic_status;
            end
            `P2M_OFS_ID_LOW: begin
                rd_mux = ID_LOW;
            end
            `P2M_OFS_ID_HIGH: begin
                rd_mux = ID_HIGH;
            end
            `P2M_OFS_ADVERTISE: begin
                rd_mux = advertise;
            end
            `P2M_OFS_PARTNER: begin
                rd_mux = partner;
            end
            `P2M_OFS_RSVD_LO, `P2M_OFS_RSVD_HI: begin
                rd_mux = 16'h0000;
            end
            `P2M_OFS_EVT_STATUS: begin
                rd_mux = evt_status;
            end
            `P2M_OFS_EVT_MASK: begin
                rd_mux = evt_mask_word;
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end else begin
            reg_rdata_r <= 16'h0000;
        end
    end

endmodule

// ==== tb/p2m_link_partner.sv ====
`timescale 1ns/1ps
module p2m_link_partner (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Commanded line state
    input wire link,
    input wire aneg,
    input wire fef,
    input wire [4:0] abil,
    // Port status view
    output reg [15:0] status_r
);
    // Negotiated results exist only while the link is up
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= 16'h0;
        end else begin
            status_r <= {7'h0, fef, 1'b0, aneg & link, link, link ? abil : 5'h0};
        end
    end
endmodule

// ==== tb/p2m_regs_monitor.sv ====
`timescale 1ns/1ps
module p2m_regs_monitor #(
    parameter [15:0] ID_LOW = 16'h5a5a,
    parameter [15:0] ID_HIGH = 16'h0c3c
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_r,
    // Side inputs
    input wire cr4_wr,
    input wire [15:0] cr4_wdata,
    input wire [15:0] port2_status,
    // Levels out
    input wire dis_auto_mdix,
    input wire dis_far_end_fault,
    input wire dis_transmit,
    input wire adv_pause,
    input wire [3:0] adv_abilities,
    input wire irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_CTRL_RD: assert property (reg_rd && reg_addr == 8'h58 |=> reg_rdata_r ==
        {12'h0, $past(dis_auto_mdix), $past(dis_far_end_fault), $past(dis_transmit), 1'b0})
        else $error("control readback wrong");
    AST_STAT_RD: assert property (reg_rd && reg_addr == 8'h5a |=> reg_rdata_r ==
        {5'h0f, 5'h0, $past(port2_status[6]), $past(port2_status[8]), 1'b1,
        $past(port2_status[5]), 2'b00}) else $error("status readback wrong");
    AST_IDL_RD: assert property (reg_rd && reg_addr == 8'h5c |=> reg_rdata_r == ID_LOW)
        else $error("identifier low readback wrong");
    AST_ID_RD: assert property (reg_rd && reg_addr == 8'h5e |=> reg_rdata_r == ID_HIGH)
        else $error("identifier readback wrong");
    AST_ADV_RD: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata_r ==
        {5'h0, $past(adv_pause), 1'b0, $past(adv_abilities), 5'h01})
        else $error("advertise readback wrong");
    AST_LP_RD: assert property (reg_rd && reg_addr == 8'h62 |=> reg_rdata_r ==
        {5'h0, $past(port2_status[4]), 1'b0, $past(port2_status[3:0]), 5'h01})
        else $error("partner readback wrong");
    AST_RSVD_RD: assert property (reg_rd && reg_addr[7:1] == 7'h32 |=>
        reg_rdata_r == 16'h0) else $error("reserved readback not zero");
    AST_IDLE_RD: assert property (!reg_rd |=> reg_rdata_r == 16'h0)
        else $error("read data outside its cycle");
    AST_CTRL_WR: assert property (reg_wr && reg_addr == 8'h58 |=>
        {dis_auto_mdix, dis_far_end_fault, dis_transmit} == $past(reg_wdata[3:1]))
        else $error("control write not applied");
    AST_ADV_WR: assert property (reg_wr && reg_addr == 8'h60 |=>
        {adv_pause, adv_abilities} == {$past(reg_wdata[10]), $past(reg_wdata[8:5])})
        else $error("advertise write not applied");
    AST_CR4_WR: assert property (cr4_wr && !reg_wr |=>
        adv_abilities == $past(cr4_wdata[3:0]) && dis_transmit == $past(cr4_wdata[14]))
        else $error("shared field write lost");
    AST_HOLD: assert property (!reg_wr && !cr4_wr |=>
        $stable({dis_transmit, adv_abilities})) else $error("levels changed without a write");
    cover property (reg_rd && reg_addr == 8'h5a);
    cover property (cr4_wr && !reg_wr);
    cover property ($rose(irq));
endmodule

// ==== tb/port2_phy_mii_register_view_tb_top.sv ====
`timescale 1ns/1ps
module port2_phy_mii_register_view_tb_top;
    localparam [15:0] IDL = 16'h1357;
    localparam [15:0] IDH = 16'h2468;
    reg clock, arst_n, reg_wr, reg_rd, cr4_wr, lp_link, lp_aneg, lp_fef;
    reg [7:0] reg_addr;
    reg [15:0] reg_wdata, cr4_wdata, d, v;
    reg [4:0] lp_abil, e;
    wire [15:0] reg_rdata_r, sr;
    wire dis_auto_mdix, dis_far_end_fault, dis_transmit, adv_pause, irq;
    wire [3:0] adv_abilities;
    wire [2:0] dis_all;
    integer errors, n_compared, seed, i;
    p2m_regs #(.ID_LOW(IDL), .ID_HIGH(IDH)) p2m_regs_i (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .cr4_wr(cr4_wr), .cr4_wdata(cr4_wdata), .port2_status(sr),
        .dis_auto_mdix(dis_auto_mdix), .dis_far_end_fault(dis_far_end_fault),
        .dis_transmit(dis_transmit), .adv_pause(adv_pause), .adv_abilities(adv_abilities),
        .irq(irq));
    p2m_link_partner p2m_link_partner_i (.clock(clock), .arst_n(arst_n), .link(lp_link),
        .aneg(lp_aneg), .fef(lp_fef), .abil(lp_abil), .status_r(sr));
    assign dis_all = {dis_auto_mdix, dis_far_end_fault, dis_transmit};
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [15:0] x);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= x;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(negedge clock);
    endtask
    task rd(input [7:0] a, output [15:0] x);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        x = reg_rdata_r;
    endtask
    task c4(input [15:0] x);
        @(posedge clock);
        cr4_wr <= 1'b1;
        cr4_wdata <= x;
        @(posedge clock);
        cr4_wr <= 1'b0;
        @(negedge clock);
    endtask
    task lp(input [7:0] x);
        @(posedge clock);
        {lp_link, lp_aneg, lp_fef, lp_abil} <= x;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask
    function [15:0] f_stat(input [15:0] s);
        f_stat = {5'h0f, 5'h0, s[6], s[8], 1'b1, s[5], 2'b00};
    endfunction
    task conclude;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        {errors, n_compared, seed, arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
        {cr4_wr, cr4_wdata, lp_link, lp_aneg, lp_fef, lp_abil} = 0;
        seed = 38610;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rd(8'h58, d);
        check("ctrl_rst", d, 16'h0000);
        rd(8'h5a, d);
        check("stat_rst", d, 16'h7808);
        rd(8'h60, d);
        check("adv_rst", d, 16'h05e1);
        for (i = 0; i < 24; i = i + 1) begin
            v = 16'($random(seed));
            lp(v[7:0]);
            rd(8'h5a, d);
            check("status", d, f_stat(sr));
            rd(8'h62, d);
            check("partner", d, {5'h0, sr[4], 1'b0, sr[3:0], 5'h01});
            wr(8'h58, v);
            check("ctl_out", dis_all, v[3:1]);
            rd(8'h58, d);
            check("ctrl", d, {12'h0, v[3:1], 1'b0});
            v = 16'($random(seed));
            e = v[15] ? {v[10], v[8:5]} : {v[4], v[3:0]};
            if (v[15]) begin
                wr(8'h60, v);
            end else begin
                c4(v);
                check("cr4_out", dis_all, {v[10], v[12], v[14]});
            end
            check("adv_out", {adv_pause, adv_abilities}, e);
            rd(8'h60, d);
            check("adv", d, {5'h0, e[4], 1'b0, e[3:0], 5'h01});
        end
        rd(8'h60, v);
        wr(8'h5c, 16'hffff);
        wr(8'h64, 16'hffff);
        wr(8'h65, 16'hffff);
        wr(8'h80, 16'hffff);
        rd(8'h5c, d);
        check("id_low", d, IDL);
        rd(8'h5e, d);
        check("id_high", d, IDH);
        rd(8'h64, d);
        check("rsvd", d, 16'h0);
        rd(8'h65, d);
        check("rsvd_hi", d, 16'h0);
        rd(8'h60, d);
        check("adv_kept", d, v);
        wr(8'hf2, 16'h0);
        wr(8'hf0, 16'h000f);
        rd(8'hf0, d);
        check("evt_clr", d, 16'h0);
        lp({~lp_link, lp_aneg, lp_fef, lp_abil});
        check("irq_masked", irq, 16'h0);
        rd(8'hf0, d);
        check("evt", d & 16'h0001, 16'h0001);
        wr(8'hf2, 16'h0001);
        check("irq", irq, 16'h0001);
        wr(8'hf0, 16'h0001);
        check("irq_clr", irq, 16'h0);
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors = errors + 1;
        conclude;
    end
endmodule
bind p2m_regs p2m_regs_monitor #(.ID_LOW(ID_LOW), .ID_HIGH(ID_HIGH)) p2m_regs_monitor_i (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .cr4_wr(cr4_wr),
    .cr4_wdata(cr4_wdata), .port2_status(port2_status), .dis_auto_mdix(dis_auto_mdix),
    .dis_far_end_fault(dis_far_end_fault), .dis_transmit(dis_transmit),
    .adv_pause(adv_pause), .adv_abilities(adv_abilities), .irq(irq));
